//--- sfch_handler.sv
// Feature-configuration command decoder, checker and value store.
// Assumes an admin front end that hands over one command at a time and
// a fetch engine that reads attribute buffers from host memory.
`timescale 1ns/1ps
// What the document requires of this block and its host
// (R1) Only both pointers, dwords 10 and 11 used
// (R2) First pointer starts buffer; ignored without buffer
// (R3) Second pointer only for remainder, never list
// (R4) Save flag set: keep value across resets
// (R5) Save support advertised in capability bit four
// (R6) Save on unsaveable feature: abort, not saveable
// (R7) Identifier in dword 10 bits 7 to 0
// (R8) Reset restores defaults of non-persistent features
// (R9) Defaults fixed, never changed by command
// (R10) New value applies after successful completion
// (R11) Host drains outstanding commands first
// (R12) Nine mandatory identifiers always supported
// (R13) Only 03h, 0Ch, 81h use memory buffer
// (R14) 0Ch optional, not persistent, buffer based
// (R15) Reserved, command-set and vendor ranges classified
// (R16) 03h, 80h, 83h persist when saving unsupported
// (R17) 81h mandatory when reservations supported
// (R18) 82h, 83h mandatory with namespace reservations
// (R19) Inactive namespace with vendor identifier: accepted
// (R20) Reserved or unsupported identifier: invalid field
// (R21) Completion only after attributes fetched, applied
module sfch_handler
   import sfch_pkg::*;
#(
   parameter logic        SAVE_SUPPORTED = 1'b1,
   parameter logic        OPT_RANGE      = 1'b1,
   parameter logic        OPT_CACHE      = 1'b1,
   parameter logic        OPT_APST       = 1'b1,
   parameter logic        OPT_SWPM       = 1'b1,
   parameter logic        OPT_HOSTID     = 1'b0,
   parameter logic        OPT_VENDOR     = 1'b1,
   parameter logic [31:0] DEFAULT_VALUE  = SFCH_VALUE_RST
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        cmd_valid,
   input  wire logic [63:0] cmd_ptr1,
   input  wire logic [63:0] cmd_ptr2,
   input  wire logic [31:0] cmd_dw10,
   input  wire logic [31:0] cmd_dw11,
   input  wire logic        ns_inactive,
   input  wire logic        ctrl_resv_cap,
   input  wire logic        ns_resv_cap_nz,
   input  wire logic        fetch_done,
   input  wire logic [7:0]  query_fid,
   output logic             cmd_ready,
   output logic             fetch_req,
   output logic [63:0]      fetch_addr1,
   output logic [63:0]      fetch_addr2,
   output logic             fetch_use2,
   output logic             cpl_valid,
   output logic [7:0]       cpl_status,
   output logic             save_cap,
   output logic [31:0]      query_value,
   output logic             query_saved
);
   // Full byte identifiers need an identifier space of 256 entries
   initial begin
      if (SFCH_NUM_FEAT != 256) $error("sfch_handler: identifier space must be 256");
   end

   sfch_state_type state, next_state;
   logic [7:0]  fid, next_fid;
   logic        save, next_save;
   logic [31:0] dw11, next_dw11;
   logic [63:0] ptr1, next_ptr1, ptr2, next_ptr2;
   logic        use2, next_use2;
   logic        busy_fetch, next_busy_fetch;
   logic        cpl, next_cpl;
   logic [7:0]  status, next_status;
   logic [31:0] cur [SFCH_NUM_FEAT];
   logic        saved [SFCH_NUM_FEAT];
   logic [31:0] qv, next_qv;
   logic        qs, next_qs;
   logic        supported, buffered, persistent, saveable;
   logic        write_en;
   // Output flops: ready, remainder address and capability
   logic        ready, next_ready;
   logic [63:0] addr2, next_addr2;
   logic        cap;

   // Classify the latched identifier
   always_comb begin
      supported = 1'b0;                                              // [R15] [R20]
      buffered  = 1'b0;
      persistent = 1'b0;
      if (fid >= SFCH_FID_ARB && fid <= SFCH_FID_AEC && fid != SFCH_FID_RANGE
          && fid != SFCH_FID_CACHE)
         supported = 1'b1;                                           // [R12]
      else if (fid == SFCH_FID_RANGE)
         supported = OPT_RANGE;
      else if (fid == SFCH_FID_CACHE)
         supported = OPT_CACHE;
      else if (fid == SFCH_FID_APST)
         supported = OPT_APST;                                       // [R14]
      else if (fid == SFCH_FID_SWPM)
         supported = OPT_SWPM;                                       // [R15]
      else if (fid == SFCH_FID_HOSTID)
         supported = OPT_HOSTID | ctrl_resv_cap;                     // [R17]
      else if (fid == SFCH_FID_RNMASK || fid == SFCH_FID_RPERSIST)
         supported = ns_resv_cap_nz;                                 // [R18]
      else if (fid >= SFCH_FID_VENDOR)
         supported = OPT_VENDOR;                                     // [R19]
      if (fid == SFCH_FID_RANGE || fid == SFCH_FID_APST || fid == SFCH_FID_HOSTID)
         buffered = 1'b1;                                            // [R13] [R14]
      if (fid == SFCH_FID_RANGE || fid == SFCH_FID_SWPM || fid == SFCH_FID_RPERSIST)
         persistent = 1'b1;                                          // [R16]
      saveable = SAVE_SUPPORTED ? 1'b1 : persistent;                 // [R6]
   end

   // Command sequencing
   always_comb begin
      next_state      = state;
      next_fid        = fid;
      next_save       = save;
      next_dw11       = dw11;
      next_ptr1       = ptr1;
      next_ptr2       = ptr2;
      next_use2       = use2;
      next_busy_fetch = 1'b0;
      next_cpl        = 1'b0;
      next_status     = status;
      write_en        = 1'b0;
      case (state)
         SFCH_IDLE: begin
            if (cmd_valid) begin
               next_fid  = cmd_dw10[SFCH_FID_MSB:SFCH_FID_LSB];     // [R7] [R1]
               next_save = cmd_dw10[SFCH_SAVE_BIT];                  // [R4]
               next_dw11 = cmd_dw11;
               next_ptr1 = cmd_ptr1;                                 // [R2]
               next_ptr2 = cmd_ptr2;
               // Remainder pointer only when buffer crosses a page
               next_use2 = (cmd_ptr1[11:0] != 12'h000);              // [R3]
               next_state = SFCH_CHECK;
            end
         end
         SFCH_CHECK: begin
            if (!supported) begin
               next_status = SFCH_ST_BAD_FIELD;                      // [R20]
               next_cpl    = 1'b1;
               next_state  = SFCH_DONE;
            end else if (save && !saveable) begin
               next_status = SFCH_ST_NOT_SAVE;                       // [R6]
               next_cpl    = 1'b1;
               next_state  = SFCH_DONE;
            end else if (buffered) begin
               next_busy_fetch = 1'b1;                               // [R2]
               next_state      = SFCH_FETCH;
            end else begin
               next_state = SFCH_APPLY;
            end
         end
         SFCH_FETCH: begin
            next_busy_fetch = !fetch_done;
            if (fetch_done)
               next_state = SFCH_APPLY;                              // [R21]
         end
         SFCH_APPLY: begin
            write_en    = 1'b1;                                      // [R10]
            next_status = SFCH_ST_OK;
            next_cpl    = 1'b1;                                      // [R21]
            next_state  = SFCH_DONE;
         end
         SFCH_DONE: begin
            next_state = SFCH_IDLE;
         end
         default: next_state = SFCH_IDLE;
      endcase
      // Readback port, one cycle of latency
      next_qv = cur[query_fid];
      next_qs = saved[query_fid];
      // Ready follows the next state so the port comes from a flop
      next_ready = (next_state == SFCH_IDLE);
      // Remainder address shows zero unless a page is crossed
      next_addr2 = next_use2 ? next_ptr2 : 64'h0000_0000_0000_0000;  // [R3]
   end

   // Registered outputs that need no sequencing state of their own
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ready <= 1'b1;
         addr2 <= 64'h0000_0000_0000_0000;
         cap   <= SAVE_SUPPORTED;                                    // [R5]
      end else begin
         ready <= next_ready;
         addr2 <= next_addr2;
         cap   <= SAVE_SUPPORTED;                                    // [R5]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state      <= SFCH_IDLE;
         fid        <= 8'h00;
         save       <= 1'b0;
         dw11       <= SFCH_VALUE_RST;
         ptr1       <= 64'h0000_0000_0000_0000;
         ptr2       <= 64'h0000_0000_0000_0000;
         use2       <= 1'b0;
         busy_fetch <= 1'b0;
         cpl        <= 1'b0;
         status     <= SFCH_ST_OK;
         qv         <= SFCH_VALUE_RST;
         qs         <= 1'b0;
      end else begin
         state      <= next_state;
         fid        <= next_fid;
         save       <= next_save;
         dw11       <= next_dw11;
         ptr1       <= next_ptr1;
         ptr2       <= next_ptr2;
         use2       <= next_use2;
         busy_fetch <= next_busy_fetch;
         cpl        <= next_cpl;
         status     <= next_status;
         qv         <= next_qv;
         qs         <= next_qs;
      end
   end

   // Feature value store; saved entries survive controller reset
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < SFCH_NUM_FEAT; i++) begin
         if (!rst_n) begin
            if (!saved[i] && !(i == 3 || i == 128 || i == 131))
               cur[i] <= DEFAULT_VALUE;                              // [R8] [R9]
         end else if (write_en && fid == i[7:0]) begin
            cur[i] <= dw11;
         end
      end
   end

   // Save marks, held across controller reset
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < SFCH_NUM_FEAT; i++) begin
         if (write_en && fid == i[7:0] && save)
            saved[i] <= 1'b1;                                        // [R4]
         else if (saved[i] === 1'bx)
            saved[i] <= 1'b0;
      end
   end

   // Every output is taken straight from a flop
   assign cmd_ready   = ready;
   assign fetch_req   = busy_fetch;
   assign fetch_addr1 = ptr1;
   assign fetch_addr2 = addr2;
   assign fetch_use2  = use2;
   assign cpl_valid   = cpl;
   assign cpl_status  = status;
   assign save_cap    = cap;                                         // [R5]
   assign query_value = qv;
   assign query_saved = qs;
endmodule // sfch_handler

//--- sfch_pkg.sv
// Constants for the feature-configuration command handler.
// Assumes one 50 MHz clock and a synchronous active-low reset.
package sfch_pkg;
   localparam int SFCH_FID_LSB        = 0;
   localparam int SFCH_FID_MSB        = 7;
   localparam int SFCH_SAVE_BIT       = 31;
   localparam int SFCH_ONCS_SAVE_BIT  = 4;
   localparam int SFCH_NUM_FEAT       = 256;
   localparam int SFCH_PAGE_BYTES     = 4096;
   localparam logic [7:0] SFCH_FID_ARB      = 8'h01;
   localparam logic [7:0] SFCH_FID_PWR      = 8'h02;
   localparam logic [7:0] SFCH_FID_RANGE    = 8'h03;
   localparam logic [7:0] SFCH_FID_TEMP     = 8'h04;
   localparam logic [7:0] SFCH_FID_ERR      = 8'h05;
   localparam logic [7:0] SFCH_FID_CACHE    = 8'h06;
   localparam logic [7:0] SFCH_FID_QCNT     = 8'h07;
   localparam logic [7:0] SFCH_FID_COAL     = 8'h08;
   localparam logic [7:0] SFCH_FID_IVEC     = 8'h09;
   localparam logic [7:0] SFCH_FID_ATOM     = 8'h0A;
   localparam logic [7:0] SFCH_FID_AEC      = 8'h0B;
   localparam logic [7:0] SFCH_FID_APST     = 8'h0C;
   localparam logic [7:0] SFCH_FID_RSV_LO   = 8'h0D;
   localparam logic [7:0] SFCH_FID_RSV_HI   = 8'h7F;
   localparam logic [7:0] SFCH_FID_SWPM     = 8'h80;
   localparam logic [7:0] SFCH_FID_HOSTID   = 8'h81;
   localparam logic [7:0] SFCH_FID_RNMASK   = 8'h82;
   localparam logic [7:0] SFCH_FID_RPERSIST = 8'h83;
   localparam logic [7:0] SFCH_FID_CSS_RSV  = 8'h84;
   localparam logic [7:0] SFCH_FID_VENDOR   = 8'hC0;
   // Completion status codes
   localparam logic [7:0] SFCH_ST_OK        = 8'h00;
   localparam logic [7:0] SFCH_ST_BAD_FIELD = 8'h02;
   localparam logic [7:0] SFCH_ST_NOT_SAVE  = 8'h0D;
   localparam logic [31:0] SFCH_VALUE_RST   = 32'h0000_0000;
   typedef enum logic [2:0] {
      SFCH_IDLE,
      SFCH_CHECK,
      SFCH_FETCH,
      SFCH_APPLY,
      SFCH_DONE
   } sfch_state_type;
endpackage

//--- sfch_fetch_model.sv
// Fetch engine model answering buffer fetches from host memory.
// Assumes fetch_req stays high until the handler sees fetch_done.
`timescale 1ns/1ps
module sfch_fetch_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       fetch_req,
   input  wire logic [3:0] wait_cycles,
   output logic            fetch_done
);
   logic [3:0] cnt;
   logic       served;
   // One done pulse per request, after wait_cycles
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !fetch_req) begin
         cnt        <= 4'h0;
         fetch_done <= 1'b0;
         served     <= 1'b0;
      end else begin
         fetch_done <= !served && cnt == wait_cycles;
         served     <= served || cnt == wait_cycles;
         cnt        <= cnt + 4'h1;
      end
   end
endmodule // sfch_fetch_model

//--- sfch_handler_checker.sv
// Port checker for the feature-configuration handler.
// Assumes it is bound to sfch_handler.
`timescale 1ns/1ps
module sfch_handler_checker
   import sfch_pkg::*;
#(parameter logic SAVE_SUPPORTED = 1'b1) (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        cmd_valid,
   input wire logic [31:0] cmd_dw10,
   input wire logic        cmd_ready,
   input wire logic        fetch_req,
   input wire logic        fetch_use2,
   input wire logic [63:0] fetch_addr2,
   input wire logic        cpl_valid,
   input wire logic [7:0]  cpl_status,
   input wire logic        save_cap
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Decoded request classes
   wire logic [7:0] fid  = cmd_dw10[7:0];
   wire logic       take = cmd_valid && cmd_ready && !cmd_dw10[31];
   wire logic       mand = fid inside {8'h01, 8'h02, 8'h04, 8'h05, [8'h07:8'h0b]};
   wire logic       rsv  = fid inside {8'h00, [8'h0d:8'h7f], [8'h84:8'hbf]};
   chk_save_cap_const: assert property (save_cap == SAVE_SUPPORTED) else $error("save cap wrong");
   chk_cpl_one_cycle: assert property (cpl_valid |=> !cpl_valid) else $error("cpl not a pulse");
   chk_busy_after_take: assert property (take |=> !cmd_ready) else $error("ready while busy");
   chk_addr2_unused: assert property (fetch_req && !fetch_use2 |-> fetch_addr2 == 64'h0)
      else $error("addr2 not zero");
   chk_cpl_after_fetch: assert property (fetch_req |-> !cpl_valid) else $error("cpl during fetch");
   chk_rsv_bad_field: assert property (take && rsv |-> ##[1:4] cpl_valid && cpl_status == SFCH_ST_BAD_FIELD)
      else $error("reserved id accepted");
   chk_mand_ok: assert property (take && mand |-> ##[1:4] cpl_valid && cpl_status == SFCH_ST_OK)
      else $error("mandatory id refused");
   chk_mand_no_fetch: assert property (take && mand |=> !fetch_req [*4]) else $error("fetch for dword id");
   chk_buf_fetch: assert property (take && fid inside {8'h03, 8'h0c} |-> ##[1:3] fetch_req)
      else $error("no fetch for buffer id");
   cov_fetch: cover property (take ##[1:3] fetch_req);
   cov_bad: cover property (cpl_valid && cpl_status == SFCH_ST_BAD_FIELD);
   cov_ok: cover property (cpl_valid && cpl_status == SFCH_ST_OK);
endmodule // sfch_handler_checker
bind sfch_handler sfch_handler_checker #(.SAVE_SUPPORTED(SAVE_SUPPORTED)) u_chk (.ref_clk(ref_clk),
   .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_dw10(cmd_dw10), .cmd_ready(cmd_ready), .fetch_req(fetch_req),
   .fetch_use2(fetch_use2), .fetch_addr2(fetch_addr2), .cpl_valid(cpl_valid), .cpl_status(cpl_status),
   .save_cap(save_cap));

//--- tb.sv
// Self-checking bench for the feature-configuration handler.
// Assumes the fetch model stands in for host memory.
`timescale 1ns/1ps
module tb;
   import sfch_pkg::*;
   logic ref_clk, rst_n, cmd_valid, ns_inactive, ctrl_resv_cap, ns_resv_cap_nz, fetch_done, cmd_ready;
   logic fetch_req, fetch_use2, cpl_valid, save_cap, query_saved;
   logic [63:0] cmd_ptr1, cmd_ptr2, fetch_addr1, fetch_addr2;
   logic [31:0] cmd_dw10, cmd_dw11, query_value;
   logic [7:0]  query_fid, cpl_status, ns_status;
   logic [3:0]  wait_cycles;
   int          n_errors, total_checks;
   logic [7:0]  mand [9] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
   logic [7:0]  rsv [5] = '{8'h00, 8'h0d, 8'h7f, 8'h84, 8'hbf};
   sfch_handler dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ptr1(cmd_ptr1),
      .cmd_ptr2(cmd_ptr2), .cmd_dw10(cmd_dw10), .cmd_dw11(cmd_dw11), .ns_inactive(ns_inactive),
      .ctrl_resv_cap(ctrl_resv_cap), .ns_resv_cap_nz(ns_resv_cap_nz), .fetch_done(fetch_done),
      .query_fid(query_fid), .cmd_ready(cmd_ready), .fetch_req(fetch_req), .fetch_addr1(fetch_addr1),
      .fetch_addr2(fetch_addr2), .fetch_use2(fetch_use2), .cpl_valid(cpl_valid), .cpl_status(cpl_status),
      .save_cap(save_cap), .query_value(query_value), .query_saved(query_saved));
   // Second handler without save support, fed the same commands
   sfch_handler #(.SAVE_SUPPORTED(1'b0)) dut_nosave (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ptr1(cmd_ptr1), .cmd_ptr2(cmd_ptr2), .cmd_dw10(cmd_dw10), .cmd_dw11(cmd_dw11),
      .ns_inactive(ns_inactive), .ctrl_resv_cap(ctrl_resv_cap), .ns_resv_cap_nz(ns_resv_cap_nz),
      .fetch_done(fetch_done), .query_fid(query_fid), .cmd_ready(), .fetch_req(), .fetch_addr1(),
      .fetch_addr2(), .fetch_use2(), .cpl_valid(), .cpl_status(ns_status), .save_cap(), .query_value(),
      .query_saved());
   sfch_fetch_model u_fetch (.ref_clk(ref_clk), .rst_n(rst_n), .fetch_req(fetch_req),
      .wait_cycles(wait_cycles), .fetch_done(fetch_done));
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_reset;
      rst_n = 0;
      repeat (12) @(negedge ref_clk);
      rst_n = 1;
   endtask
   // One command, then completion status, fetch and pointer checks
   task automatic send(input logic [7:0] fid, input logic sv, input logic [31:0] v, input logic [63:0] p1,
                       input logic [7:0] st, input logic fx);
      int n;
      logic f;
      logic [63:0] a1, a2;
      logic u2;
      f = 0; n = 0; a1 = 0; a2 = 0; u2 = 0;
      while (cmd_ready !== 1'b1 && n < 50) begin @(negedge ref_clk); n++; end
      cmd_dw10 = {sv, 23'h5a_5a5a, fid}; cmd_dw11 = v; cmd_ptr1 = p1; cmd_valid = 1;
      @(negedge ref_clk);
      cmd_valid = 0; n = 0;
      while (cpl_valid !== 1'b1 && n < 50) begin
         if (fetch_req === 1'b1) begin f = 1; a1 = fetch_addr1; a2 = fetch_addr2; u2 = fetch_use2; end
         @(negedge ref_clk); n++;
      end
      chk(cpl_status, st);
      chk(f, fx);
      if (fx) begin
         chk(a1, p1);
         chk(u2, p1[11:0] != 0);
         chk(a2, (p1[11:0] != 0) ? cmd_ptr2 : 64'h0);
      end
   endtask
   task automatic query(input logic [7:0] fid, input logic [31:0] v);
      query_fid = fid;
      repeat (2) @(negedge ref_clk);
      chk(query_value, v);
   endtask
   initial begin
      cmd_valid = 0; cmd_ptr1 = 0; cmd_ptr2 = 64'h0000_0000_0002_0000; cmd_dw10 = 0; cmd_dw11 = 0;
      ns_inactive = 0; ctrl_resv_cap = 0; ns_resv_cap_nz = 0; query_fid = 0; wait_cycles = 4'h5;
      do_reset;
      chk(save_cap, 1'b1);
      foreach (mand[i]) begin
         send(mand[i], 0, {24'h00_0a50, mand[i]}, 0, SFCH_ST_OK, 0);
         query(mand[i], {24'h00_0a50, mand[i]});
      end
      foreach (rsv[i]) send(rsv[i], 0, 0, 0, SFCH_ST_BAD_FIELD, 0);
      send(8'h03, 0, 1, 64'h0000_0000_0000_1000, SFCH_ST_OK, 1);
      wait_cycles = 4'h0;
      send(8'h0c, 0, 2, 64'h0000_0000_0000_1010, SFCH_ST_OK, 1);
      send(8'h81, 0, 3, 64'h0000_0000_0000_2000, SFCH_ST_BAD_FIELD, 0);
      ctrl_resv_cap = 1;
      send(8'h81, 0, 3, 64'h0000_0000_0000_2000, SFCH_ST_OK, 1);
      ns_resv_cap_nz = 1;
      send(8'h82, 0, 4, 0, SFCH_ST_OK, 0);
      ns_inactive = 1;
      send(8'hc0, 0, 5, 0, SFCH_ST_OK, 0);
      send(8'h80, 0, 32'h1234_5678, 0, SFCH_ST_OK, 0);
      send(8'h02, 1, 32'h0000_0003, 0, SFCH_ST_OK, 0);
      chk(ns_status, SFCH_ST_NOT_SAVE);
      do_reset;
      query(8'h01, SFCH_VALUE_RST);
      query(8'h80, 32'h1234_5678);
      query(8'h02, 32'h0000_0003);
      chk(query_saved, 1'b1);
      print_verdict;
   end
   // Cut a hang short
   initial begin
      #400000;
      n_errors++;
      print_verdict;
   end
endmodule // tb
